/* File: hw/serial_port_two_consts.vh */
// Constants for the second serial port: register map, field positions, states
// Operation
// - Receive flag; interrupt needs both enables
// - Clock source select set gives master
// - Synchronous transfers are half-duplex
// - Sync select plus enable remap pins
// - Master drives the shift clock out
// - Shifter reloads only after last bit
// - Buffer-to-shifter load sets transmit flag
// - Transmit flag clears only on buffer write
// - Transmit interrupt enable gates transmit interrupt
// - Shifter-empty bit read-only, no interrupt
// - Buffer write with transmit enabled starts
// - Single or continuous enable starts reception
// - Data sampled on falling clock edge
// - Single gets one word; continuous wins
// - Clock source clear gives external-clock slave
// - Slave works in any low-power mode
// - Words shift least significant bit first
// - Transmit enable sets transmit empty flag
`ifndef SERIAL_PORT_TWO_CONSTS_VH
`define SERIAL_PORT_TWO_CONSTS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define REG_FLAG 4'h0
`define REG_ENABLE 4'h1
`define REG_PRIO 4'h2
`define REG_RXSC 4'h3
`define REG_RXBUF 4'h4
`define REG_TXSC 4'h5
`define REG_BAUD 4'h6
`define REG_TXBUF 4'h7
`define REG_IRQCTL 4'h8

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TXSC_CLKSRC 7
`define TXSC_NINE 6
`define TXSC_TRANSMIT_ENABLE 5
`define TXSC_SYNC 4
`define TXSC_HIGHBAUD 2
`define TXSC_NINTH 0
`define RXSC_PEN 7
`define RXSC_NINE 6
`define RXSC_SINGLE 5
`define RXSC_CONT 4
`define RXSC_ADDR 3
`define FLAG_RX 5
`define FLAG_TX 4
`define IRQ_GLOBAL 7
`define IRQ_PERIPH 6
`define TXSC_MASK 8'hF5
`define RXSC_MASK 8'hF8
`define FLAG_MASK 8'h30
`define IRQCTL_MASK 8'hC0

// ----------------------------------------------------------------------------
// Reset values, counts, states
// ----------------------------------------------------------------------------
`define RST_BYTE 8'h00
`define LAST_BIT8 4'h7
`define LAST_BIT9 4'h8
`define OVS_HIGH 7'h0F
`define OVS_LOW 7'h3F
`define ST_IDLE 4'h1
`define ST_TX 4'h2
`define ST_RX 4'h4
`define ST_ARX 4'h8

`endif

/* File: hw/pin_sync.v */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
   parameter W = 2
) (
   // Clock and reset
   input wire mclk,
   input wire resetn,
   // Levels
   input wire [W-1:0] level,
   output reg [W-1:0] level_q
);
   reg [W-1:0] meta_q;

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= {W{1'b0}};
         level_q <= {W{1'b0}};
      end else begin
         meta_q <= level;
         level_q <= meta_q;
      end
   end
endmodule // pin_sync

/* File: hw/baud_tick.v */
// Baud divider: one-cycle tick every divisor+1 clocks
`timescale 1ns/1ps
module baud_tick #(
   parameter W = 8
) (
   // Clock and reset
   input wire mclk,
   input wire resetn,
   // Control
   input wire [W-1:0] divisor,
   input wire restart,
   output reg tick_q
);
   reg [W-1:0] count_q;

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         count_q <= {W{1'b0}};
         tick_q <= 1'b0;
      end else if (restart || count_q >= divisor) begin
         // Restart keeps the first bit of a frame a full period long
         count_q <= {W{1'b0}};
         tick_q <= !restart;
      end else begin
         count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
         tick_q <= 1'b0;
      end
   end
endmodule // baud_tick

/* File: hw/serial_port_two.v */
// Second serial port: sync master/slave transfers, async address-detect receive
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "serial_port_two_consts.vh"
module serial_port_two (
   // Clock and reset
   input wire mclk,
   input wire resetn,
   // Register port
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata_q,
   // Clock line (transmit pin in async mode)
   input wire shift_clock_line_level,
   output reg shift_clock_line_drive_q,
   output reg shift_clock_line_en_q,
   // Data line (receive pin in async mode)
   input wire shift_data_line_level,
   output reg shift_data_line_drive_q,
   output reg shift_data_line_en_q,
   // Interrupt request
   output reg irq_request_q
);
   reg [7:0] txsc_q, rxsc_q, enable_q, prio_q, irqctl_q, baud_q;
   reg [7:0] txbuf_q, rxbuf_q;
   reg txbuf9_q, txfull_q, rxflag_q, rx9_q, framing_error_q, overrun_error_q;
   reg [8:0] txsh_q, rxsh_q;
   reg txsh_full_q, ck_prev_q;
   reg [3:0] state_q, bitcnt_q;
   reg [6:0] subcnt_q;
   reg [7:0] rd_mux;
   wire [1:0] pins_q;
   wire tick;

   function [3:0] last_index;
      input nine;
      begin
         last_index = nine ? `LAST_BIT9 : `LAST_BIT8;
      end
   endfunction

   // -------------------------------------------------------------------------
   // Mode decode
   // -------------------------------------------------------------------------
   wire pen = rxsc_q[`RXSC_PEN];
   wire sync_mode = pen & txsc_q[`TXSC_SYNC];
   wire master = txsc_q[`TXSC_CLKSRC];
   wire transmit_enable = txsc_q[`TXSC_TRANSMIT_ENABLE];
   wire single_receive_enable = rxsc_q[`RXSC_SINGLE];
   wire continuous_receive_enable = rxsc_q[`RXSC_CONT];
   wire nine_rx = rxsc_q[`RXSC_NINE];
   wire st_idle = state_q[0];
   wire st_tx = state_q[1];
   wire st_rx = state_q[2];
   wire st_arx = state_q[3];
   wire ck_s = pins_q[1];
   wire dt_s = pins_q[0];

   pin_sync #(.W(2)) u_sync (
      .mclk(mclk),
      .resetn(resetn),
      .level({shift_clock_line_level, shift_data_line_level}),
      .level_q(pins_q)
   );

   baud_tick #(.W(8)) u_baud (
      .mclk(mclk),
      .resetn(resetn),
      .divisor(baud_q),
      .restart(st_idle),
      .tick_q(tick)
   );

   // -------------------------------------------------------------------------
   // Shift clock events
   // -------------------------------------------------------------------------
   // Master toggles its own clock on each tick; slave follows the pin, so
   // nothing here stops in a low-power state of the core
   wire m_rise = tick & ~shift_clock_line_drive_q;
   wire m_fall = tick & shift_clock_line_drive_q;
   wire s_rise = ck_s & ~ck_prev_q;
   wire s_fall = ~ck_s & ck_prev_q;
   wire rise_e = master ? m_rise : s_rise;
   wire fall_e = master ? m_fall : s_fall;
   wire [8:0] rx_next = {dt_s, rxsh_q[8:1]};

   // Async sampling point
   wire [6:0] ovs = txsc_q[`TXSC_HIGHBAUD] ? `OVS_HIGH : `OVS_LOW;
   wire samp = st_arx & tick & (subcnt_q == ovs);
   wire [3:0] stop_idx = last_index(nine_rx) + 4'h2;

   // -------------------------------------------------------------------------
   // Receive completion
   // -------------------------------------------------------------------------
   wire tx_last = (bitcnt_q == last_index(txsc_q[`TXSC_NINE]));
   wire rx_last = (bitcnt_q == last_index(nine_rx));
   wire srx_done = st_rx & fall_e & rx_last;
   wire arx_done = samp & (bitcnt_q == stop_idx);
   wire rx_done = srx_done | arx_done;
   wire [8:0] rx_src = st_rx ? rx_next : rxsh_q;
   wire [8:0] rx_word = nine_rx ? rx_src : {1'b0, rx_src[8:1]};
   wire rx_keep = ~(st_arx & rxsc_q[`RXSC_ADDR] & nine_rx & ~rx_word[8]);
   wire rx_take = rx_done & rx_keep & ~rxflag_q;
   wire rx_over = rx_done & rx_keep & rxflag_q;
   wire rd_rxbuf = rd & (addr == `REG_RXBUF);
   wire wr_txbuf = wr & (addr == `REG_TXBUF);
   wire wr_rxsc = wr & (addr == `REG_RXSC);
   wire wr_txsc = wr & (addr == `REG_TXSC);
   wire tx_flag = ~txfull_q;

   // Load from buffer into shifter: idle, or straight after the last bit
   wire tx_ready = sync_mode & transmit_enable & txfull_q & ~st_rx & ~st_arx;
   wire tx_end = st_tx & fall_e & tx_last;
   wire tx_load = tx_ready & ((st_idle & ~txsh_full_q) | tx_end);

   // -------------------------------------------------------------------------
   // Register writes and flags
   // -------------------------------------------------------------------------
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         txsc_q <= `RST_BYTE;
         rxsc_q <= `RST_BYTE;
         enable_q <= `RST_BYTE;
         prio_q <= `RST_BYTE;
         irqctl_q <= `RST_BYTE;
         baud_q <= `RST_BYTE;
         txbuf_q <= `RST_BYTE;
         txbuf9_q <= 1'b0;
         txfull_q <= 1'b0;
         rxbuf_q <= `RST_BYTE;
         rxflag_q <= 1'b0;
         rx9_q <= 1'b0;
         framing_error_q <= 1'b0;
         overrun_error_q <= 1'b0;
      end else begin
         if (wr_txsc) begin
            txsc_q <= wdata & `TXSC_MASK;
         end
         if (wr & (addr == `REG_ENABLE)) begin
            enable_q <= wdata & `FLAG_MASK;
         end
         if (wr & (addr == `REG_PRIO)) begin
            prio_q <= wdata & `FLAG_MASK;
         end
         if (wr & (addr == `REG_IRQCTL)) begin
            irqctl_q <= wdata & `IRQCTL_MASK;
         end
         if (wr & (addr == `REG_BAUD)) begin
            baud_q <= wdata;
         end
         if (wr_rxsc) begin
            rxsc_q <= wdata & `RXSC_MASK;
         end else if (srx_done & ~continuous_receive_enable) begin
            rxsc_q[`RXSC_SINGLE] <= 1'b0;
         end
         // Overrun clears when continuous receive is written clear; a new overrun wins
         if (rx_over) begin
            overrun_error_q <= 1'b1;
         end else if (wr_rxsc & ~wdata[`RXSC_CONT]) begin
            overrun_error_q <= 1'b0;
            framing_error_q <= 1'b0;
         end
         if (rx_take) begin
            rxbuf_q <= rx_word[7:0];
            rx9_q <= rx_word[8];
            framing_error_q <= arx_done & ~dt_s;
         end
         // A word landing in the same cycle as the read keeps the flag set
         if (rx_take) begin
            rxflag_q <= 1'b1;
         end else if (rd_rxbuf) begin
            rxflag_q <= 1'b0;
         end
         // Write of new data wins over the load that empties the buffer
         if (wr_txbuf) begin
            txbuf_q <= wdata;
            txbuf9_q <= txsc_q[`TXSC_NINTH];
            txfull_q <= 1'b1;
         end else if (wr_txsc & wdata[`TXSC_TRANSMIT_ENABLE] & ~transmit_enable) begin
            txfull_q <= 1'b0;
         end else if (tx_load) begin
            txfull_q <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Transfer engine
   // -------------------------------------------------------------------------
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_q <= `ST_IDLE;
         bitcnt_q <= 4'h0;
         subcnt_q <= 7'h00;
         txsh_q <= 9'h000;
         txsh_full_q <= 1'b0;
         rxsh_q <= 9'h000;
         ck_prev_q <= 1'b0;
         shift_clock_line_drive_q <= 1'b0;
         shift_data_line_drive_q <= 1'b0;
      end else begin
         ck_prev_q <= ck_s;
         if (!pen) begin
            state_q <= `ST_IDLE;
            txsh_full_q <= 1'b0;
            shift_clock_line_drive_q <= 1'b0;
         end else begin
            case (state_q)
               `ST_IDLE: begin
                  bitcnt_q <= 4'h0;
                  shift_clock_line_drive_q <= ~sync_mode;
                  if (tx_load) begin
                     txsh_q <= {txbuf9_q, txbuf_q};
                     txsh_full_q <= 1'b1;
                     state_q <= `ST_TX;
                  end else if (sync_mode & (single_receive_enable | continuous_receive_enable) & ~txfull_q & ~txsh_full_q) begin
                     state_q <= `ST_RX;
                     shift_clock_line_drive_q <= 1'b0;
                  end else if (~sync_mode & continuous_receive_enable & ~dt_s) begin
                     // Start edge: first sample lands mid start bit
                     subcnt_q <= {1'b0, ovs[6:1]};
                     state_q <= `ST_ARX;
                  end
               end
               `ST_TX: begin
                  if (master & tick) begin
                     shift_clock_line_drive_q <= ~shift_clock_line_drive_q;
                  end
                  if (rise_e) begin
                     shift_data_line_drive_q <= txsh_q[0];
                     txsh_q <= {1'b0, txsh_q[8:1]};
                  end
                  if (!transmit_enable || !sync_mode) begin
                     txsh_full_q <= 1'b0;
                     state_q <= `ST_IDLE;
                  end else if (fall_e) begin
                     bitcnt_q <= bitcnt_q + 4'h1;
                     if (tx_last) begin
                        bitcnt_q <= 4'h0;
                        if (tx_load) begin
                           txsh_q <= {txbuf9_q, txbuf_q};
                        end else begin
                           txsh_full_q <= 1'b0;
                           state_q <= `ST_IDLE;
                        end
                     end
                  end
               end
               `ST_RX: begin
                  if (master & tick) begin
                     shift_clock_line_drive_q <= ~shift_clock_line_drive_q;
                  end
                  if (fall_e) begin
                     rxsh_q <= rx_next;
                     bitcnt_q <= bitcnt_q + 4'h1;
                  end
                  if (!(single_receive_enable | continuous_receive_enable) || !sync_mode) begin
                     state_q <= `ST_IDLE;
                  end else if (srx_done) begin
                     bitcnt_q <= 4'h0;
                     if (!continuous_receive_enable) begin
                        state_q <= `ST_IDLE;
                     end
                  end
               end
               `ST_ARX: begin
                  if (tick) begin
                     subcnt_q <= samp ? 7'h00 : subcnt_q + 7'h01;
                  end
                  if (!continuous_receive_enable || sync_mode) begin
                     state_q <= `ST_IDLE;
                  end else if (samp) begin
                     bitcnt_q <= bitcnt_q + 4'h1;
                     if (bitcnt_q == 4'h0) begin
                        if (dt_s) begin
                           state_q <= `ST_IDLE;
                        end
                     end else if (arx_done) begin
                        state_q <= `ST_IDLE;
                     end else begin
                        rxsh_q <= rx_next;
                     end
                  end
               end
               default: begin
                  state_q <= `ST_IDLE;
               end
            endcase
         end
      end
   end

   // -------------------------------------------------------------------------
   // Read port, pin enables, interrupt
   // -------------------------------------------------------------------------
   always @* begin
      rd_mux = `RST_BYTE;
      case (addr)
         `REG_FLAG: rd_mux = {2'b00, rxflag_q, tx_flag, 4'h0};
         `REG_ENABLE: rd_mux = enable_q;
         `REG_PRIO: rd_mux = prio_q;
         `REG_RXSC: rd_mux = {rxsc_q[7:3], framing_error_q, overrun_error_q, rx9_q};
         `REG_RXBUF: rd_mux = rxbuf_q;
         `REG_TXSC: rd_mux = {txsc_q[7:2], ~txsh_full_q, txsc_q[0]};
         `REG_BAUD: rd_mux = baud_q;
         `REG_IRQCTL: rd_mux = irqctl_q;
         default: rd_mux = `RST_BYTE;
      endcase
   end

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= `RST_BYTE;
         shift_clock_line_en_q <= 1'b0;
         shift_data_line_en_q <= 1'b0;
         irq_request_q <= 1'b0;
      end else begin
         rdata_q <= rd ? rd_mux : `RST_BYTE;
         // Async: clock pin holds the idle mark; sync slave never drives it
         shift_clock_line_en_q <= pen & (~txsc_q[`TXSC_SYNC] | master);
         shift_data_line_en_q <= sync_mode & st_tx;
         irq_request_q <= ((rxflag_q & enable_q[`FLAG_RX]) | (tx_flag & enable_q[`FLAG_TX]))
            & irqctl_q[`IRQ_GLOBAL] & irqctl_q[`IRQ_PERIPH];
      end
   end
endmodule // serial_port_two

/* File: test/remote_serial_model.sv */
// Far-side serial device model for the clock/data link
`timescale 1ns/1ps
module remote_serial_model (
   // Link
   input wire clk_line,
   input wire data_line,
   output reg clk_out,
   output reg data_out,
   // Control
   input wire [7:0] tx_word,
   input wire tx_on,
   output reg [15:0] rx_word
);
   integer tx_idx;
   initial begin
      clk_out = 1'b0;
      data_out = 1'b1;
      tx_idx = 0;
      rx_word = 16'h0000;
   end
   // Newest bit enters at the top, so the first bit ends lowest
   always @(negedge clk_line) begin
      rx_word <= {data_line, rx_word[15:1]};
   end
   // New bit on the rise keeps it steady across the sampling fall
   always @(posedge clk_line) begin
      if (tx_on) begin
         data_out <= tx_word[tx_idx];
         tx_idx <= (tx_idx + 1) % 8;
      end
   end
   // A released line must not keep showing the last bit
   always @(negedge tx_on) begin
      data_out <= ~data_out;
      tx_idx <= 0;
   end
   task idle_high;
      data_out = 1'b1;
   endtask
   // External shift clock stands still outside these bursts
   task make_clock(input integer n);
      begin
         // Keep pin edges off the sampling edge of the core clock
         #10;
         repeat (n) begin
            #200 clk_out = 1'b1;
            #200 clk_out = 1'b0;
         end
      end
   endtask
   task send_frame(input [8:0] w, input stop, input integer t);
      integer i;
      begin
         #10;
         data_out = 1'b0;
         #(t * 50);
         for (i = 0; i < 9; i = i + 1) begin
            data_out = w[i];
            #(t * 50);
         end
         data_out = stop;
         #(t * 50);
         data_out = 1'b1;
         #(t * 50);
      end
   endtask
endmodule // remote_serial_model

/* File: test/serial_port_two_chk.sv */
// Assertions on the second serial port's pins and interrupt request
`timescale 1ns/1ps
`include "serial_port_two_consts.vh"
module serial_port_two_chk (
   // Clock and reset
   input wire mclk,
   input wire resetn,
   // Register port
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   input wire [7:0] rdata_q,
   // Link
   input wire shift_clock_line_level,
   input wire shift_clock_line_drive_q,
   input wire shift_clock_line_en_q,
   input wire shift_data_line_level,
   input wire shift_data_line_drive_q,
   input wire shift_data_line_en_q,
   // Interrupt
   input wire irq_request_q
);
   // Only bits that software alone changes are mirrored
   reg [7:0] txsc_q, en_q, ctl_q, baud_q;
   reg pen_q;
   reg [15:0] hi_q, since_q;
   wire mst = pen_q & txsc_q[`TXSC_SYNC] & txsc_q[`TXSC_CLKSRC];
   wire slv = pen_q & txsc_q[`TXSC_SYNC] & ~txsc_q[`TXSC_CLKSRC];
   wire asy = pen_q & ~txsc_q[`TXSC_SYNC];
   wire gp = ctl_q[`IRQ_GLOBAL] & ctl_q[`IRQ_PERIPH];
   wire en_any = en_q[`FLAG_RX] | en_q[`FLAG_TX];
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         txsc_q <= 8'h00;
         en_q <= 8'h00;
         ctl_q <= 8'h00;
         baud_q <= 8'h00;
         pen_q <= 1'b0;
         hi_q <= 16'h0000;
         since_q <= 16'h0000;
      end else begin
         if (wr && addr == `REG_TXSC)
            txsc_q <= wdata;
         if (wr && addr == `REG_ENABLE)
            en_q <= wdata;
         if (wr && addr == `REG_IRQCTL)
            ctl_q <= wdata;
         if (wr && addr == `REG_BAUD)
            baud_q <= wdata;
         if (wr && addr == `REG_RXSC)
            pen_q <= wdata[`RXSC_PEN];
         hi_q <= shift_clock_line_drive_q ? hi_q + 16'h0001 : 16'h0000;
         // A mode write may legally cut the current clock phase short
         since_q <= (wr && (addr == `REG_RXSC || addr == `REG_TXSC)) ? 16'h0000 : since_q + {15'h0000, ~&since_q};
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   master_drives_clock_a: assert property (mst && $past(mst) && $past(mst, 2) |-> shift_clock_line_en_q)
      else $error("clock line not driven in master mode");
   slave_clock_input_a: assert property (slv && $past(slv) && $past(slv, 2) |-> !shift_clock_line_en_q)
      else $error("clock line driven in slave mode");
   port_off_idle_a: assert property (!pen_q && !$past(pen_q) |=> !shift_clock_line_en_q && !shift_data_line_en_q)
      else $error("pin driven with port disabled");
   async_data_input_a: assert property (asy && $past(asy) && $past(asy, 2) |-> !shift_data_line_en_q)
      else $error("data line driven in async mode");
   irq_needs_global_a: assert property (!gp && !$past(gp) |-> !irq_request_q)
      else $error("interrupt without global enables");
   irq_needs_enable_a: assert property (!en_any && !$past(en_any) |-> !irq_request_q)
      else $error("interrupt without source enable");
   irq_has_cause_a: assert property ($rose(irq_request_q) |-> $past(gp) && $past(en_any))
      else $error("interrupt rose without enables");
   clock_half_period_a: assert property (mst && $past(mst) && $past(mst, 2) && since_q > hi_q + 16'h0002
      && $fell(shift_clock_line_drive_q) |-> hi_q == {8'h00, baud_q} + 16'h0001)
      else $error("master clock high time wrong");
endmodule // serial_port_two_chk
bind serial_port_two serial_port_two_chk u_chk (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata_q(rdata_q), .shift_clock_line_level(shift_clock_line_level),
   .shift_clock_line_drive_q(shift_clock_line_drive_q), .shift_clock_line_en_q(shift_clock_line_en_q),
   .shift_data_line_level(shift_data_line_level), .shift_data_line_drive_q(shift_data_line_drive_q),
   .shift_data_line_en_q(shift_data_line_en_q), .irq_request_q(irq_request_q));

/* File: test/test_serial_port_two.sv */
// Self-checking bench for the second serial port
`timescale 1ns/1ps
`include "serial_port_two_consts.vh"
module test_serial_port_two;
   // Baud 4 with high baud: (4+1)*16 clocks a bit
   localparam integer bit_cyc = 80;
   reg mclk, resetn, wr, rd, far_on;
   reg [3:0] addr;
   reg [7:0] wdata, far_word, v;
   wire [7:0] rdata_q;
   wire clk_drv, clk_en, dat_drv, dat_en, irq, far_clk, far_dat;
   wire [15:0] far_rx;
   wire clk_wire = clk_en ? clk_drv : far_clk;
   wire data_wire = dat_en ? dat_drv : far_dat;
   integer n_mismatch, comparisons;
   serial_port_two u_dut (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata_q(rdata_q), .shift_clock_line_level(clk_wire), .shift_clock_line_drive_q(clk_drv),
      .shift_clock_line_en_q(clk_en), .shift_data_line_level(data_wire), .shift_data_line_drive_q(dat_drv),
      .shift_data_line_en_q(dat_en), .irq_request_q(irq));
   remote_serial_model u_far (.clk_line(clk_wire), .data_line(data_wire), .clk_out(far_clk),
      .data_out(far_dat), .tx_word(far_word), .tx_on(far_on), .rx_word(far_rx));
   // --------
   // Access tasks
   // --------
   task chk(input string nm, input [15:0] seen, input [15:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task wr_reg(input [3:0] a, input [7:0] d);
      begin
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge mclk);
         wr <= 1'b0;
         @(posedge mclk);
      end
   endtask
   task rd_reg(input [3:0] a, output [7:0] d);
      begin
         addr <= a;
         rd <= 1'b1;
         @(posedge mclk);
         rd <= 1'b0;
         #1 d = rdata_q;
         @(posedge mclk);
      end
   endtask
   task rd_chk(input string nm, input [3:0] a, input [7:0] e);
      begin
         rd_reg(a, v);
         chk(nm, v, e);
      end
   endtask
   task wait_bit(input string nm, input [3:0] a, input integer b, input e);
      integer i;
      begin
         rd_reg(a, v);
         for (i = 0; i < 2000 && v[b] !== e; i = i + 1)
            rd_reg(a, v);
         chk(nm, v[b], e);
      end
   endtask
   task tally_and_finish;
      begin
         $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
         if (n_mismatch == 0 && comparisons > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   // --------
   // Tests
   // --------
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial begin
      #2000000;
      n_mismatch = n_mismatch + 1;
      tally_and_finish;
   end
   initial begin
      resetn = 1'b0; wr = 1'b0; rd = 1'b0; far_on = 1'b0;
      addr = 4'h0; wdata = 8'h00; far_word = 8'h00;
      n_mismatch = 0;
      comparisons = 0;
      repeat (12) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      rd_chk("txsc", `REG_TXSC, 8'h02);
      rd_chk("rxsc", `REG_RXSC, 8'h00);
      rd_chk("unmapped", 4'hF, 8'h00);
      wr_reg(`REG_FLAG, 8'h00);
      rd_chk("flags", `REG_FLAG, 8'h10);
      // Master transmit; data written before enabling is discarded
      wr_reg(`REG_BAUD, 8'h04);
      wr_reg(`REG_RXSC, 8'h80);
      wr_reg(`REG_TXSC, 8'h90);
      wr_reg(`REG_TXBUF, 8'hFF);
      wr_reg(`REG_TXSC, 8'hB0);
      rd_chk("flags", `REG_FLAG, 8'h10);
      rd_chk("txsc", `REG_TXSC, 8'hB2);
      wr_reg(`REG_TXBUF, 8'hA5);
      @(posedge mclk);
      wr_reg(`REG_TXBUF, 8'h3C);
      rd_chk("flags", `REG_FLAG, 8'h00);
      rd_chk("txsc", `REG_TXSC, 8'hB0);
      wr_reg(`REG_ENABLE, 8'h10);
      wr_reg(`REG_IRQCTL, 8'hC0);
      chk("irq", irq, 1'b0);
      wait_bit("flags", `REG_FLAG, 4, 1'b1);
      repeat (2) @(posedge mclk);
      chk("irq", irq, 1'b1);
      wait_bit("txsc", `REG_TXSC, 1, 1'b1);
      chk("far rx", far_rx, 16'h3CA5);
      wr_reg(`REG_TXSC, 8'hF1);
      wr_reg(`REG_TXBUF, 8'h96);
      wait_bit("txsc", `REG_TXSC, 1, 1'b1);
      chk("far rx9", far_rx[15:7], 16'h0196);
      wr_reg(`REG_ENABLE, 8'h00);
      repeat (2) @(posedge mclk);
      chk("irq", irq, 1'b0);
      // Master receive, single then continuous
      wr_reg(`REG_TXSC, 8'h90);
      far_word <= 8'h5A;
      far_on <= 1'b1;
      wr_reg(`REG_ENABLE, 8'h20);
      wr_reg(`REG_RXSC, 8'hA0);
      wait_bit("flags", `REG_FLAG, 5, 1'b1);
      repeat (2) @(posedge mclk);
      chk("irq", irq, 1'b1);
      rd_chk("rxsc", `REG_RXSC, 8'h80);
      rd_chk("rxbuf", `REG_RXBUF, 8'h5A);
      rd_chk("flags", `REG_FLAG, 8'h10);
      wr_reg(`REG_RXSC, 8'hB0);
      wait_bit("flags", `REG_FLAG, 5, 1'b1);
      rd_chk("rxbuf", `REG_RXBUF, 8'h5A);
      wait_bit("flags", `REG_FLAG, 5, 1'b1);
      rd_chk("rxbuf", `REG_RXBUF, 8'h5A);
      rd_chk("rxsc", `REG_RXSC, 8'hB0);
      wr_reg(`REG_RXSC, 8'h80);
      far_on <= 1'b0;
      wr_reg(`REG_ENABLE, 8'h00);
      // Async address detect: a ninth bit of 0 is dropped
      u_far.idle_high;
      wr_reg(`REG_TXSC, 8'h04);
      wr_reg(`REG_RXSC, 8'hD8);
      u_far.send_frame(9'h033, 1'b1, bit_cyc);
      rd_chk("flags", `REG_FLAG, 8'h10);
      u_far.send_frame(9'h177, 1'b1, bit_cyc);
      wait_bit("flags", `REG_FLAG, 5, 1'b1);
      rd_chk("rxsc", `REG_RXSC, 8'hD9);
      rd_chk("rxbuf", `REG_RXBUF, 8'h77);
      wr_reg(`REG_RXSC, 8'hD0);
      u_far.send_frame(9'h0AB, 1'b0, bit_cyc);
      wait_bit("rxsc", `REG_RXSC, 2, 1'b1);
      wr_reg(`REG_RXSC, 8'hC0);
      wait_bit("rxsc", `REG_RXSC, 2, 1'b0);
      rd_chk("rxbuf", `REG_RXBUF, 8'hAB);
      // Slave receive from an external clock
      wr_reg(`REG_RXSC, 8'h00);
      wr_reg(`REG_TXSC, 8'h10);
      wr_reg(`REG_RXSC, 8'h90);
      far_word <= 8'hC3;
      far_on <= 1'b1;
      u_far.make_clock(8);
      wait_bit("flags", `REG_FLAG, 5, 1'b1);
      rd_chk("rxbuf", `REG_RXBUF, 8'hC3);
      far_on <= 1'b0;
      tally_and_finish;
   end
endmodule // test_serial_port_two
